/* File: css_defs.svh */
// Constants for the command source switch: register offsets, field layout, resets.
// Assumes inclusion by the main module only.
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH

// ******************************************************************
// Register offsets (byte addresses)
// ******************************************************************
`define CSS_OFF_PRI_SRC     12'h000
`define CSS_OFF_ALT_SRC     12'h004
`define CSS_OFF_TERM_FN_LO  12'h008
`define CSS_OFF_TERM_FN_HI  12'h00C
`define CSS_OFF_KEY_FREQ    12'h010
`define CSS_OFF_COMM        12'h014
`define CSS_OFF_STATUS      12'h018
`define CSS_OFF_FREQ_OUT    12'h01C

// ******************************************************************
// Field positions and codes
// ******************************************************************
`define CSS_RUN_LSB         0
`define CSS_FREQ_LSB        4
`define CSS_FN_W            5
`define CSS_FN_ALT_SOURCE   5'h16
`define CSS_NUM_INPUTS      5

// ******************************************************************
// Reset values
// ******************************************************************
`define CSS_RST_RUN_SEL     2'h1
`define CSS_RST_FREQ_SEL    4'h0
`define CSS_RST_ALT_FREQ    3'h0
`define CSS_RST_FN_P5       5'h07

`endif

/* File: css_pkg.sv */
// Types shared by the command source switch modules.
// Assumes nothing beyond the constant header.
package css_pkg;

    typedef enum logic [1:0] {
        CSS_RUN_KEYPAD   = 2'h0,
        CSS_RUN_TERM_DIR = 2'h1,
        CSS_RUN_TERM_RUN = 2'h2,
        CSS_RUN_COMM     = 2'h3
    } css_run_sel_t;

    typedef struct packed {
        logic       keypad_run;
        logic       keypad_rev;
        logic       fwd_term;
        logic       rev_term;
        logic       comm_run;
        logic       comm_rev;
    } css_run_in_t;

    typedef struct packed {
        logic       run;
        logic       reverse;
    } css_run_cmd_t;

    typedef struct packed {
        logic [15:0] key_freq;
        logic [15:0] key_freq2;
        logic [15:0] pot;
        logic [15:0] ai_volt;
        logic [15:0] ai_curr;
        logic [15:0] comm_freq;
    } css_freq_in_t;

endpackage : css_pkg

/* File: css_run_decode.sv */
// Decodes the run command from the source named by one run-source selector.
// Assumes inputs are synchronous to pclk.
`timescale 1ns/1ps
module css_run_decode (
    input  wire logic               [1:0] sel,
    input  wire css_pkg::css_run_in_t     run_in,
    output      css_pkg::css_run_cmd_t    cmd
);
    always_comb begin
        cmd = '0;
        unique case (css_pkg::css_run_sel_t'(sel))
            // RULE4 keypad key only
            css_pkg::CSS_RUN_KEYPAD: begin
                cmd.run     = run_in.keypad_run;
                cmd.reverse = run_in.keypad_rev;
            end
            // RULE5 forward and reverse terminals
            css_pkg::CSS_RUN_TERM_DIR: begin
                cmd.run     = run_in.fwd_term ^ run_in.rev_term;
                cmd.reverse = run_in.rev_term & ~run_in.fwd_term;
            end
            // RULE6 run plus direction
            css_pkg::CSS_RUN_TERM_RUN: begin
                cmd.run     = run_in.fwd_term;
                cmd.reverse = run_in.rev_term;
            end
            // RULE7 link run command
            css_pkg::CSS_RUN_COMM: begin
                cmd.run     = run_in.comm_run;
                cmd.reverse = run_in.comm_rev;
            end
        endcase
    end
endmodule : css_run_decode

/* File: css_freq_select.sv */
// Picks the frequency reference named by a frequency-source selector.
// Assumes analog values are already digitised and synchronous to pclk.
`timescale 1ns/1ps
module css_freq_select (
    input  wire logic                 [3:0]  sel,
    input  wire css_pkg::css_freq_in_t       fin,
    output      logic                 [15:0] freq,
    output      logic                        valid
);
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[16] ? 16'hFFFF : s[15:0];
    endfunction : sat_add

    always_comb begin
        freq  = 16'h0000;
        valid = 1'b1;
        case (sel)
            // RULE8 keypad digital modes
            4'h0: freq = fin.key_freq;
            4'h1: freq = fin.key_freq2;
            // RULE9 analog references
            4'h2: freq = fin.pot;
            4'h3: freq = fin.ai_volt;
            4'h4: freq = fin.ai_curr;
            4'h5: freq = sat_add(fin.pot, fin.ai_curr);
            4'h6: freq = sat_add(fin.pot, fin.ai_volt);
            // RULE10 link reference
            4'h7: freq = fin.comm_freq;
            default: valid = 1'b0;
        endcase
    end
endmodule : css_freq_select

/* File: css_switch.sv */
// Command source switch: APB registers, terminal function decode, source select.
// Assumes an APB master on pclk and terminal inputs synchronous to pclk.
// Functional notes
// RULE1: Any of the five input terminals whose function code is 22 acts as the alternate-source input.
// RULE2: While that input is on, run commands come from the alternate run-source selector.
// RULE3: While that input is on, the frequency reference comes from the alternate frequency selector.
// RULE4: Run-source value 0 takes run and stop only from the keypad key.
// RULE5: Run-source value 1 treats one terminal as forward run and another as reverse run.
// RULE6: Run-source value 2 treats one terminal as run/stop and the other as direction.
// RULE7: Run-source value 3 takes run commands from the RS-485 link.
// RULE8: Frequency-source values 0 and 1 select keypad digital modes 1 and 2.
// RULE9: Frequency-source values 2 to 6 select the pot, voltage, current, or pot plus current or voltage.
// RULE10: Frequency-source value 7 takes the reference from the RS-485 link.
// RULE11: Asserting the input while running switches sources without stopping first.
// RULE12: Releasing the input reverts to primary sources and stops if those give no run.
// RULE13: Frequency reference and run command change together on a switch.
// RULE14: The operator should check the alternate settings before asserting the input.
// RULE15: If the newly selected source gives no run command, the drive stops.
// RULE16: The input is sampled once per cycle and the selection applies from the next cycle.
`timescale 1ns/1ps
`include "css_defs.svh"
module css_switch (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output      logic [31:0]           prdata,
    output      logic                  pready,
    output      logic                  pslverr,
    input  wire logic [4:0]            term_in,
    input  wire css_pkg::css_run_in_t  run_in,
    input  wire css_pkg::css_freq_in_t freq_in,
    output      logic                  run_cmd,
    output      logic                  reverse_cmd,
    output      logic [15:0]           freq_ref,
    output      logic                  alt_active
);
    // ******************************************************************
    // Registers
    // ******************************************************************
    logic [1:0]  run_source_sel_q;
    logic [3:0]  freq_source_sel_q;
    logic [1:0]  alt_run_source_sel_q;
    logic [2:0]  alt_freq_source_sel_q;
    logic [24:0] input_terminal_function_sel_q;
    logic [15:0] key_freq_q;
    logic [15:0] key_freq2_q;
    logic        comm_run_q;
    logic        comm_rev_q;
    logic        alt_sel_q;
    logic        run_cmd_q;
    logic        reverse_cmd_q;
    logic [15:0] freq_ref_q;
    logic        freq_fault_q;

    logic        wr_en;
    logic        rd_en;
    logic        addr_hit;
    logic        alt_level;
    logic [1:0]  run_sel_mux;
    logic [3:0]  freq_sel_mux;
    css_pkg::css_run_in_t  run_mux_in;
    css_pkg::css_freq_in_t freq_mux_in;
    css_pkg::css_run_cmd_t run_dec;
    logic [15:0] freq_dec;
    logic        freq_ok;

    // ******************************************************************
    // APB slave
    // ******************************************************************
    // Zero-wait slave: each access completes in its first access cycle.
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite & addr_hit;
    assign rd_en   = psel & penable & ~pwrite;
    assign pslverr = psel & penable & ~addr_hit;

    always_comb begin
        addr_hit = 1'b1;
        case (paddr)
            `CSS_OFF_PRI_SRC, `CSS_OFF_ALT_SRC, `CSS_OFF_TERM_FN_LO, `CSS_OFF_TERM_FN_HI,
            `CSS_OFF_KEY_FREQ, `CSS_OFF_COMM, `CSS_OFF_STATUS, `CSS_OFF_FREQ_OUT: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_source_sel_q      <= `CSS_RST_RUN_SEL;
            freq_source_sel_q     <= `CSS_RST_FREQ_SEL;
            alt_run_source_sel_q  <= `CSS_RST_RUN_SEL;
            alt_freq_source_sel_q <= `CSS_RST_ALT_FREQ;
        end else if (wr_en && paddr == `CSS_OFF_PRI_SRC) begin
            run_source_sel_q  <= pwdata[`CSS_RUN_LSB +: 2];
            freq_source_sel_q <= pwdata[`CSS_FREQ_LSB +: 4];
        end else if (wr_en && paddr == `CSS_OFF_ALT_SRC) begin
            alt_run_source_sel_q  <= pwdata[`CSS_RUN_LSB +: 2];
            alt_freq_source_sel_q <= pwdata[`CSS_FREQ_LSB +: 3];
        end
    end

    // Function codes for the five terminals, five bits each; the fifth one resets to 7.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_terminal_function_sel_q <= {`CSS_RST_FN_P5, 20'h00000};
        end else if (wr_en && paddr == `CSS_OFF_TERM_FN_LO) begin
            input_terminal_function_sel_q[19:0] <= pwdata[19:0];
        end else if (wr_en && paddr == `CSS_OFF_TERM_FN_HI) begin
            input_terminal_function_sel_q[24:20] <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_freq_q  <= 16'h0000;
            key_freq2_q <= 16'h0000;
        end else if (wr_en && paddr == `CSS_OFF_KEY_FREQ) begin
            key_freq_q  <= pwdata[15:0];
            key_freq2_q <= pwdata[31:16];
        end
    end

    // Link run bits may also arrive as register writes from the link handler.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comm_run_q <= 1'b0;
            comm_rev_q <= 1'b0;
        end else if (wr_en && paddr == `CSS_OFF_COMM) begin
            comm_run_q <= pwdata[0];
            comm_rev_q <= pwdata[1];
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `CSS_OFF_PRI_SRC:    prdata = {24'h0, freq_source_sel_q, 2'h0, run_source_sel_q};
                `CSS_OFF_ALT_SRC:    prdata = {25'h0, alt_freq_source_sel_q, 2'h0,
                                               alt_run_source_sel_q};
                `CSS_OFF_TERM_FN_LO: prdata = {12'h0, input_terminal_function_sel_q[19:0]};
                `CSS_OFF_TERM_FN_HI: prdata = {27'h0, input_terminal_function_sel_q[24:20]};
                `CSS_OFF_KEY_FREQ:   prdata = {key_freq2_q, key_freq_q};
                `CSS_OFF_COMM:       prdata = {30'h0, comm_rev_q, comm_run_q};
                `CSS_OFF_STATUS:     prdata = {28'h0, freq_fault_q, reverse_cmd_q, run_cmd_q,
                                               alt_sel_q};
                `CSS_OFF_FREQ_OUT:   prdata = {16'h0, freq_ref_q};
                default:             prdata = 32'h0000_0000;
            endcase
        end
    end

    // ******************************************************************
    // Alternate-source input
    // ******************************************************************
    // RULE1 code 22 match
    always_comb begin
        alt_level = 1'b0;
        for (int i = 0; i < `CSS_NUM_INPUTS; i++) begin
            if (input_terminal_function_sel_q[i*`CSS_FN_W +: `CSS_FN_W] == `CSS_FN_ALT_SOURCE &&
                term_in[i]) begin
                alt_level = 1'b1;
            end
        end
    end

    // RULE16 sample per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_sel_q <= 1'b0;
        end else begin
            alt_sel_q <= alt_level;
        end
    end

    // ******************************************************************
    // Source selection
    // ******************************************************************
    // RULE2 alternate run selector
    assign run_sel_mux  = alt_sel_q ? alt_run_source_sel_q : run_source_sel_q;
    // RULE3 alternate frequency selector
    assign freq_sel_mux = alt_sel_q ? {1'b0, alt_freq_source_sel_q} : freq_source_sel_q;

    always_comb begin
        run_mux_in          = run_in;
        run_mux_in.comm_run = run_in.comm_run | comm_run_q;
        run_mux_in.comm_rev = run_in.comm_rev | comm_rev_q;
        freq_mux_in           = freq_in;
        freq_mux_in.key_freq  = key_freq_q;
        freq_mux_in.key_freq2 = key_freq2_q;
    end

    css_run_decode u_run_decode (
        .sel    (run_sel_mux),
        .run_in (run_mux_in),
        .cmd    (run_dec)
    );

    css_freq_select u_freq_select (
        .sel   (freq_sel_mux),
        .fin   (freq_mux_in),
        .freq  (freq_dec),
        .valid (freq_ok)
    );

    // ******************************************************************
    // Command outputs
    // ******************************************************************
    // RULE13 update both together
    // Run and frequency share one register stage so the ramp logic never sees a mixed pair.
    // RULE11 no forced stop
    // RULE12 revert on release
    // RULE15 stop on no run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cmd_q     <= 1'b0;
            reverse_cmd_q <= 1'b0;
            freq_ref_q    <= 16'h0000;
            freq_fault_q  <= 1'b0;
        end else begin
            run_cmd_q     <= run_dec.run & freq_ok;
            reverse_cmd_q <= run_dec.reverse;
            freq_ref_q    <= freq_dec;
            freq_fault_q  <= ~freq_ok;
        end
    end

    assign run_cmd     = run_cmd_q;
    assign reverse_cmd = reverse_cmd_q;
    assign freq_ref    = freq_ref_q;
    assign alt_active  = alt_sel_q;

endmodule : css_switch

/* File: css_switch_props.sv */
// Concurrent checks for the command source switch, with shadow copies of its registers.
// Assumes a bind to css_switch; it sees only that module's ports.
`timescale 1ns/1ps
module css_switch_props (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic [4:0]            term_in,
    input wire css_pkg::css_run_in_t  run_in,
    input wire css_pkg::css_freq_in_t freq_in,
    input wire logic                  run_cmd,
    input wire logic                  reverse_cmd,
    input wire logic [15:0]           freq_ref,
    input wire logic                  alt_active
);
    logic [7:0]  pri_q;
    logic [6:0]  alt_q;
    logic [24:0] fn_q;
    logic [31:0] key_q;
    logic [1:0]  lnk_q;
    logic [3:0]  fsel;
    logic [16:0] sc, sv;
    logic [15:0] e_frq;
    logic        e_alt, e_run, e_rev;
    // Shadows follow completed writes, so expectations read back only alt_active from the design.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_q <= 8'h01;
            alt_q <= 7'h01;
            fn_q  <= {5'h07, 20'h00000};
            key_q <= 32'h00000000;
            lnk_q <= 2'h0;
        end else if (psel && penable && pready && pwrite) begin
            case (paddr)
                12'h000: pri_q <= pwdata[7:0];
                12'h004: alt_q <= pwdata[6:0];
                12'h008: fn_q[19:0] <= pwdata[19:0];
                12'h00C: fn_q[24:20] <= pwdata[4:0];
                12'h010: key_q <= pwdata;
                12'h014: lnk_q <= pwdata[1:0];
                default: ;
            endcase
        end
    end
    always_comb begin
        e_alt = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (fn_q[5*i +: 5] == 5'h16 && term_in[i]) begin
                e_alt = 1'b1;
            end
        end
        fsel = alt_active ? {1'b0, alt_q[6:4]} : pri_q[7:4];
        sc = {1'b0, freq_in.pot} + {1'b0, freq_in.ai_curr};
        sv = {1'b0, freq_in.pot} + {1'b0, freq_in.ai_volt};
        case (alt_active ? alt_q[1:0] : pri_q[1:0])
            2'h0: {e_rev, e_run} = {run_in.keypad_rev, run_in.keypad_run};
            2'h1: {e_rev, e_run} = {run_in.rev_term & ~run_in.fwd_term,
                                    run_in.fwd_term ^ run_in.rev_term};
            2'h2: {e_rev, e_run} = {run_in.rev_term, run_in.fwd_term};
            default: {e_rev, e_run} = {run_in.comm_rev | lnk_q[1], run_in.comm_run | lnk_q[0]};
        endcase
        e_run = e_run & ~fsel[3];
        case (fsel)
            4'h0: e_frq = key_q[15:0];
            4'h1: e_frq = key_q[31:16];
            4'h2: e_frq = freq_in.pot;
            4'h3: e_frq = freq_in.ai_volt;
            4'h4: e_frq = freq_in.ai_curr;
            4'h5: e_frq = sc[16] ? 16'hFFFF : sc[15:0];
            4'h6: e_frq = sv[16] ? 16'hFFFF : sv[15:0];
            4'h7: e_frq = freq_in.comm_freq;
            default: e_frq = 16'h0000;
        endcase
    end
    // ******************************************************************
    // Properties
    // ******************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence alt_on_s;
        !alt_active ##1 alt_active;
    endsequence
    sequence alt_off_s;
        alt_active ##1 !alt_active;
    endsequence
    a_alt_detect: assert property (1'b1 |=> alt_active == $past(e_alt))
        else $error("alternate flag does not follow the coded terminals");
    a_run_source: assert property (1'b1 |=> run_cmd == $past(e_run))
        else $error("run command from the wrong source");
    a_freq_source: assert property (1'b1 |=> freq_ref == $past(e_frq))
        else $error("frequency reference from the wrong source");
    a_dir_source: assert property (!fsel[3] |=> reverse_cmd == $past(e_rev))
        else $error("direction from the wrong source");
    a_switch_together: assert property (alt_on_s |=> run_cmd == $past(e_run)
        && freq_ref == $past(e_frq)) else $error("switch to alternate not applied together");
    a_revert_primary: assert property (alt_off_s |=> run_cmd == $past(e_run)
        && freq_ref == $past(e_frq)) else $error("revert to primary not applied");
    a_alt_clear: assert property (!e_alt [*2] |-> !alt_active)
        else $error("alternate flag stays set after release");
    a_bad_addr: assert property (psel && penable && paddr > 12'h01C |-> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    a_status_read: assert property (psel && penable && !pwrite && paddr == 12'h018
        |-> prdata[2:0] == {reverse_cmd, run_cmd, alt_active}) else $error("status mismatch");
endmodule : css_switch_props

/* File: css_far_side.sv */
// Far side of the switch: keypad, input terminals, analog inputs and the serial master.
// Assumes the bench sets the wanted levels just after pclk edges.
`timescale 1ns/1ps
module css_far_side (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ready_ok,
    input  wire logic [4:0]            want_term,
    input  wire css_pkg::css_run_in_t  want_run,
    input  wire css_pkg::css_freq_in_t want_freq,
    output      logic [4:0]            term_in,
    output      css_pkg::css_run_in_t  run_in,
    output      css_pkg::css_freq_in_t freq_in
);
    // Panel and link levels refresh once per control cycle, one stage behind the bench.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_in <= 5'h00;
            run_in  <= '0;
            freq_in <= '0;
        end else begin
            term_in <= want_term & {5{ready_ok}};
            run_in  <= want_run;
            freq_in <= want_freq;
        end
    end
endmodule : css_far_side

/* File: css_switch_test.sv */
// Self-checking bench for the command source switch, driven over APB.
// Assumes css_far_side feeds the terminal, panel, analog and link inputs.
`timescale 1ns/1ps
module css_switch_test;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic                  run_cmd, reverse_cmd, alt_active, ready_ok;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, key;
    logic [15:0]           freq_ref;
    logic [4:0]            term_in, want_term;
    logic [1:0]            lnk, x;
    css_pkg::css_run_in_t  run_in, want_run;
    css_pkg::css_freq_in_t freq_in, want_freq;
    logic [32:0]           exp_q[$];
    logic [11:0]           ra[8] = '{12'h000, 12'h004, 12'h008, 12'h00C,
                                     12'h010, 12'h014, 12'h018, 12'h01C};
    logic [32:0]           rv[8] = '{33'h1, 33'h1, 33'h0, 33'h7, 33'h0, 33'h0, 33'h0, 33'h0};
    int                    error_cnt = 0;
    int                    tests_run = 0;
    css_switch DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .term_in(term_in), .run_in(run_in), .freq_in(freq_in),
        .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .freq_ref(freq_ref),
        .alt_active(alt_active));
    css_far_side u_far (.pclk(pclk), .presetn(presetn), .ready_ok(ready_ok),
        .want_term(want_term), .want_run(want_run), .want_freq(want_freq),
        .term_in(term_in), .run_in(run_in), .freq_in(freq_in));
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;
    // ******************************************************************
    // Tasks and reference functions
    // ******************************************************************
    task check(input logic [32:0] seen, input logic [32:0] want);
        tests_run++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, want);
        end
    endtask : check
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
    endtask : apb
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h00000000);
    endtask : rd
    // Two edges in the switch plus one in the far side; four leaves a margin.
    task apply(input logic [4:0] t);
        @(posedge pclk);
        want_term <= t;
        repeat (4) @(posedge pclk);
    endtask : apply
    function automatic logic [1:0] xr(input logic [1:0] s, input css_pkg::css_run_in_t r,
                                      input logic [1:0] c);
        case (s)
            2'h0: xr = {r.keypad_rev, r.keypad_run};
            // Both terminals on means stop, and reverse needs the reverse terminal alone.
            2'h1: xr = {r.rev_term & ~r.fwd_term, r.fwd_term ^ r.rev_term};
            2'h2: xr = {r.rev_term, r.fwd_term};
            default: xr = {r.comm_rev | c[1], r.comm_run | c[0]};
        endcase
    endfunction : xr
    function automatic logic [15:0] xf(input logic [3:0] s, input css_pkg::css_freq_in_t v,
                                       input logic [31:0] k);
        logic [16:0] sc;
        logic [16:0] sv;
        sc = {1'b0, v.pot} + {1'b0, v.ai_curr};
        sv = {1'b0, v.pot} + {1'b0, v.ai_volt};
        case (s)
            4'h0: xf = k[15:0];
            4'h1: xf = k[31:16];
            4'h2: xf = v.pot;
            4'h3: xf = v.ai_volt;
            4'h4: xf = v.ai_curr;
            4'h5: xf = sc[16] ? 16'hFFFF : sc[15:0];
            4'h6: xf = sv[16] ? 16'hFFFF : sv[15:0];
            4'h7: xf = v.comm_freq;
            default: xf = 16'h0000;
        endcase
    endfunction : xf
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() > 0) begin
                check({pslverr, prdata}, exp_q.pop_front());
            end else begin
                check(33'h1, 33'h0);
            end
        end
    end
    // ******************************************************************
    // Main sequence
    // ******************************************************************
    initial begin
        {presetn, psel, penable, pwrite, ready_ok} = 5'h00;
        {paddr, pwdata, want_term, want_run, want_freq} = '0;
        void'($urandom(42));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], rv[i]);
        end
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        rd(12'h020, 33'h100000000);
        $display("test reset and map done");
        apb(1'b1, 12'h000, 32'h00000003);
        apb(1'b1, 12'h004, 32'h00000000);
        ready_ok <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h008, (i < 4) ? (32'h16 << (5 * i)) : 32'h0);
            apb(1'b1, 12'h00C, (i == 4) ? 32'h16 : 32'h0);
            apply(5'h01 << i);
            rd(12'h018, 33'h1);
            apply(~(5'h01 << i));
            rd(12'h018, 33'h0);
        end
        $display("test terminal function done");
        key = $urandom;
        apb(1'b1, 12'h010, key);
        for (int r = 0; r < 4; r++) begin
            for (int f = 0; f < 8; f++) begin
                lnk = 2'($urandom);
                want_run <= 6'($urandom);
                want_freq <= {$urandom, $urandom, $urandom};
                apb(1'b1, 12'h014, {30'h0, lnk});
                apb(1'b1, 12'h004, 32'((f << 4) | r));
                apply(5'h00);
                x = xr(2'h3, want_run, lnk);
                rd(12'h018, {30'h0, x, 1'b0});
                rd(12'h01C, {17'h0, key[15:0]});
                apply({1'b1, 4'($urandom)});
                x = xr(2'(r), want_run, lnk);
                rd(12'h018, {30'h0, x, 1'b1});
                rd(12'h01C, {17'h0, xf(4'(f), want_freq, key)});
            end
        end
        // A primary frequency selector above 7 names no source, so the drive must stop.
        apb(1'b1, 12'h000, 32'h00000083);
        apply(5'h00);
        x = xr(2'h3, want_run, lnk);
        rd(12'h018, {29'h0, 1'b1, x[1], 2'h0});
        rd(12'h01C, 33'h0);
        $display("test source switching done");
        print_verdict();
    end
endmodule : css_switch_test
bind css_switch css_switch_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .term_in(term_in), .run_in(run_in),
    .freq_in(freq_in), .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .freq_ref(freq_ref),
    .alt_active(alt_active));
